// file: design/uim_pkg.sv
package uim_pkg;

    // ==========================================================
    // register offsets (byte addresses on the peripheral bus)
    localparam logic [7:0] OFS_RESET     = 8'h00;
    localparam logic [7:0] OFS_DEVADDR   = 8'h08;
    localparam logic [7:0] OFS_FUNCCTL   = 8'h0c;
    localparam logic [7:0] OFS_OTGCTL    = 8'h10;
    localparam logic [7:0] OFS_OTGFLAGS  = 8'h14;
    localparam logic [7:0] OFS_SERIAL    = 8'h18;
    localparam logic [7:0] OFS_EVFLAGS   = 8'h1c;
    localparam logic [7:0] OFS_STICKY    = 8'h20;
    localparam logic [7:0] OFS_PORTMASK  = 8'h24;
    localparam logic [7:0] OFS_FRAME     = 8'h28;
    localparam logic [7:0] OFS_PID       = 8'h2c;
    localparam logic [7:0] OFS_ENDPOINT  = 8'h30;
    localparam logic [7:0] OFS_EPMATCH   = 8'h34;
    localparam logic [7:0] OFS_GENCTL    = 8'h04;

    // ==========================================================
    // field positions and reset values
    localparam int          FLAG_W        = 7;
    localparam int          BIT_TOKEN     = 6;
    localparam int          BIT_SE0       = 5;
    localparam int          BIT_K         = 4;
    localparam int          BIT_J         = 3;
    localparam int          BIT_CRC16     = 2;
    localparam int          BIT_RXACT     = 1;
    localparam int          BIT_RXERR     = 0;
    localparam int          GEN_LSDEC     = 2;
    localparam int          SER_TXEN_N    = 1;
    localparam logic [2:0]  RST_OPMODE    = 3'h1;
    localparam logic        RST_TERMSEL   = 1'h1;
    localparam logic        RST_XCVRSEL   = 1'h1;
    localparam logic [7:0]  EP_MATCH_OR   = 8'h10;
    localparam logic [3:0]  PID_SOF       = 4'h5;

    // ==========================================================
    // line state codes
    localparam logic [1:0]  LS_SE0        = 2'h0;
    localparam logic [1:0]  LS_J          = 2'h1;
    localparam logic [1:0]  LS_K          = 2'h2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       bvalid;
        logic       idGnd;
        logic       hostDis;
        logic       vbusVld;
        logic       sessVld;
        logic       sessEnd;
    } uim_otg_status_t;

    typedef struct packed {
        logic       extVbusInd;
        logic       drvVbusExt;
        logic       chrgVbus;
        logic       dischrgVbus;
        logic       dmPulldown;
        logic       dpPulldown;
        logic       idPullup;
    } uim_otg_ctl_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] pid;
        logic [6:0] addr;
        logic [3:0] endp;
        logic [10:0] frame;
        logic       crc5Ok;
        logic       pidOk;
    } uim_token_t;

endpackage : uim_pkg

// file: design/uim_regs.sv
// Notes on behaviour
// - hold 7-bit device address; only matching packets are forwarded.
// - function control drives opmode[4:2], termselect bit1, xcvrselect bit0.
// - otg control bits drive vbus, pull and id outputs; reset zero.
// - otg flags register mirrors transceiver status inputs read-only.
// - serial control reads back rxrcv, rxdm, rxdp on bits 6..4.
// - serial bits drive se0, data, serial mode; bit1 low enables tx.
// - flag 6 set on good token addressed to this device.
// - flags 5,4,3 set on line state se0, k, j.
// - flag 2 set when a data packet fails crc16.
// - flag 1 follows rxactive, flag 0 follows rxerror.
// - non-sticky flags 6..2 clear automatically when next packet arrives.
// - sticky flags hold until software writes one to that bit.
// - non-sticky flags 1 and 0 track their source, later changes overwrite.
// - each flag port is OR of flags selected by its 8-bit mask.
// - 11-bit frame number readable and writable as one field, loaded from sof tokens.
// - last received 4-bit packet id captured, resets to zero.
// - endpoint of the last non-sof token addressed to this device stored with a validity bit.
// - matched endpoint presented on receive port ORed with 0x10.
// - any write to reset register returns control, frame, pid, endpoint and flag registers to reset; rx port data is not cleared.
// - line-state flags produced only while decoder enable bit is set.
`timescale 1ns/1ns
`default_nettype none

module uim_regs
    import uim_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     nrst,
    input  wire logic                     regWrite,
    input  wire logic                     regRead,
    input  wire logic [7:0]               regAddr,
    input  wire logic [31:0]              regWdata,
    output logic      [31:0]              regRdata,
    input  wire uim_pkg::uim_token_t      token,
    input  wire logic                     packetStart,
    input  wire logic                     dataCrcFail,
    input  wire logic [1:0]               lineState,
    input  wire logic                     rxActive,
    input  wire logic                     rxError,
    input  wire logic                     rxRcv,
    input  wire logic                     rxDm,
    input  wire logic                     rxDp,
    input  wire uim_pkg::uim_otg_status_t otgStatus,
    output logic                          packetAccept,
    output logic [2:0]                    opMode,
    output logic                          termSelect,
    output logic                          xcvrSelect,
    output uim_pkg::uim_otg_ctl_t         otgCtl,
    output logic                          txSe0,
    output logic                          txData,
    output logic                          txEnable_n,
    output logic                          fsLsSerial,
    output logic                          flagPortFirst,
    output logic                          flagPortSecond,
    output logic                          flagPortThird,
    output logic [7:0]                    rxPortData,
    output logic                          rxPortValid
);
    import uim_pkg::*;

    // ==========================================================
    // input synchronisers (transceiver pins are asynchronous)
    logic [15:0] pinMeta_reg;
    logic [15:0] pinSync_reg;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pinMeta_reg <= 16'h0000;
            pinSync_reg <= 16'h0000;
        end else begin
            pinMeta_reg <= {lineState, rxActive, rxError, rxRcv, rxDm, rxDp,
                            otgStatus, 3'h0};
            pinSync_reg <= pinMeta_reg;
        end
    end
    logic [1:0]      lsSync;
    logic            rxActSync;
    logic            rxErrSync;
    logic [2:0]      rxSerSync;
    uim_otg_status_t otgSync;
    assign lsSync    = pinSync_reg[15:14];
    assign rxActSync = pinSync_reg[13];
    assign rxErrSync = pinSync_reg[12];
    assign rxSerSync = pinSync_reg[11:9];
    assign otgSync   = pinSync_reg[8:3];

    // ==========================================================
    // bus decode; a module-reset write acts as a synchronous clear
    logic modRst;
    assign modRst = regWrite && (regAddr == OFS_RESET);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = regWrite && (a == o);
    endfunction : hit

    // ==========================================================
    // control registers
    logic [6:0]  devAddr_reg;
    logic [7:0]  genCtl_reg;
    logic [4:0]  funcCtl_reg;
    logic [7:0]  otgCtl_reg;
    logic [3:0]  serial_reg;
    logic [6:0]  sticky_reg;
    logic [23:0] portMask_reg;
    logic [15:0] epMatch_reg;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            devAddr_reg  <= 7'h00;
            genCtl_reg   <= 8'h00;
            funcCtl_reg  <= {RST_OPMODE, RST_TERMSEL, RST_XCVRSEL};
            otgCtl_reg   <= 8'h00;
            serial_reg   <= 4'h2;
            sticky_reg   <= 7'h00;
            portMask_reg <= 24'h000000;
            epMatch_reg  <= 16'h0000;
        end else if (modRst) begin
            devAddr_reg  <= 7'h00;
            genCtl_reg   <= 8'h00;
            funcCtl_reg  <= {RST_OPMODE, RST_TERMSEL, RST_XCVRSEL};
            otgCtl_reg   <= 8'h00;
            serial_reg   <= 4'h2;
            sticky_reg   <= 7'h00;
            portMask_reg <= 24'h000000;
            epMatch_reg  <= 16'h0000;
        end else begin
            if (hit(regAddr, OFS_DEVADDR))  devAddr_reg  <= regWdata[6:0];
            if (hit(regAddr, OFS_GENCTL))   genCtl_reg   <= regWdata[7:0];
            if (hit(regAddr, OFS_FUNCCTL))  funcCtl_reg  <= regWdata[4:0];
            if (hit(regAddr, OFS_OTGCTL))   otgCtl_reg   <= regWdata[7:0];
            if (hit(regAddr, OFS_SERIAL))   serial_reg   <= regWdata[3:0];
            if (hit(regAddr, OFS_STICKY))   sticky_reg   <= regWdata[6:0];
            if (hit(regAddr, OFS_PORTMASK)) portMask_reg <= regWdata[23:0];
            if (hit(regAddr, OFS_EPMATCH))  epMatch_reg  <= regWdata[15:0];
        end
    end

    // ==========================================================
    // transceiver control outputs, registered
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            opMode     <= RST_OPMODE;
            termSelect <= RST_TERMSEL;
            xcvrSelect <= RST_XCVRSEL;
            otgCtl     <= '0;
            txSe0      <= 1'b0;
            txData     <= 1'b0;
            txEnable_n <= 1'b1;
            fsLsSerial <= 1'b0;
        end else begin
            opMode     <= funcCtl_reg[4:2];
            termSelect <= funcCtl_reg[1];
            xcvrSelect <= funcCtl_reg[0];
            otgCtl     <= {otgCtl_reg[7:6], otgCtl_reg[4:0]};
            txSe0      <= serial_reg[3];
            txData     <= serial_reg[2];
            txEnable_n <= serial_reg[SER_TXEN_N];
            fsLsSerial <= serial_reg[0];
        end
    end

    // ==========================================================
    // token handling
    logic tokGood;
    logic tokMine;
    assign tokGood = token.valid && token.crc5Ok && token.pidOk;
    assign tokMine = tokGood && (token.addr == devAddr_reg);

    logic [10:0] frame_reg;
    logic [3:0]  pid_reg;
    logic [4:0]  endp_reg;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            frame_reg <= 11'h000;
            pid_reg   <= 4'h0;
            endp_reg  <= 5'h00;
        end else if (modRst) begin
            frame_reg <= 11'h000;
            pid_reg   <= 4'h0;
            endp_reg  <= 5'h00;
        end else begin
            if (hit(regAddr, OFS_FRAME))
                frame_reg <= regWdata[10:0];
            else if (tokGood && token.pid == PID_SOF)
                frame_reg <= token.frame;
            if (token.valid)
                pid_reg <= token.pid;
            if (tokMine && token.pid != PID_SOF)
                endp_reg <= {1'b1, token.endp};
        end
    end

    // forward matching packets; special endpoints tagged on rx port
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            packetAccept <= 1'b0;
            rxPortValid  <= 1'b0;
            rxPortData   <= 8'h00;
        end else begin
            packetAccept <= tokMine && !modRst;
            rxPortValid  <= tokMine && !modRst;
            if (tokMine)
                rxPortData <= epMatch_reg[token.endp]
                              ? (EP_MATCH_OR | {4'h0, token.endp})
                              : {4'h0, token.endp};
        end
    end

    // ==========================================================
    // event flags: set wins over software clear
    logic [6:0] flags_reg;
    logic [6:0] flagSrc;
    logic       lsEn;
    assign lsEn = genCtl_reg[GEN_LSDEC];
    always_comb begin
        flagSrc              = 7'h00;
        flagSrc[BIT_TOKEN]   = tokMine;
        flagSrc[BIT_SE0]     = lsEn && lsSync == LS_SE0;
        flagSrc[BIT_K]       = lsEn && lsSync == LS_K;
        flagSrc[BIT_J]       = lsEn && lsSync == LS_J;
        flagSrc[BIT_CRC16]   = dataCrcFail;
        flagSrc[BIT_RXACT]   = rxActSync;
        flagSrc[BIT_RXERR]   = rxErrSync;
    end

    logic [6:0] flagClr;
    assign flagClr = hit(regAddr, OFS_EVFLAGS) ? regWdata[6:0] : 7'h00;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= 7'h00;
        end else if (modRst) begin
            flags_reg <= 7'h00;
        end else begin
            for (int i = 0; i < FLAG_W; i++) begin
                if (sticky_reg[i]) begin
                    if (flagSrc[i])
                        flags_reg[i] <= 1'b1;
                    else if (flagClr[i])
                        flags_reg[i] <= 1'b0;
                end else if (i == BIT_RXACT || i == BIT_RXERR) begin
                    flags_reg[i] <= flagSrc[i];
                end else if (flagSrc[i]) begin
                    flags_reg[i] <= 1'b1;
                end else if (packetStart) begin
                    flags_reg[i] <= 1'b0;
                end
            end
        end
    end

    // flag ports: one cycle behind the flags, straight from flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flagPortFirst  <= 1'b0;
            flagPortSecond <= 1'b0;
            flagPortThird  <= 1'b0;
        end else begin
            flagPortFirst  <= |({1'b0, flags_reg} & portMask_reg[7:0]);
            flagPortSecond <= |({1'b0, flags_reg} & portMask_reg[15:8]);
            flagPortThird  <= |({1'b0, flags_reg} & portMask_reg[23:16]);
        end
    end

    // ==========================================================
    // read data, registered; unmapped and write-only read as zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 32'h00000000;
        end else if (regRead) begin
            unique case (regAddr)
                OFS_DEVADDR:  regRdata <= {25'h0, devAddr_reg};
                OFS_GENCTL:   regRdata <= {24'h0, genCtl_reg};
                OFS_FUNCCTL:  regRdata <= {27'h0, funcCtl_reg};
                OFS_OTGCTL:   regRdata <= {24'h0, otgCtl_reg[7:6], 1'b0,
                                           otgCtl_reg[4:0]};
                OFS_OTGFLAGS: regRdata <= {26'h0, otgSync};
                OFS_SERIAL:   regRdata <= {25'h0, rxSerSync,
                                           serial_reg};
                OFS_EVFLAGS:  regRdata <= {25'h0, flags_reg};
                OFS_STICKY:   regRdata <= {25'h0, sticky_reg};
                OFS_PORTMASK: regRdata <= {8'h0, portMask_reg};
                OFS_FRAME:    regRdata <= {21'h0, frame_reg};
                OFS_PID:      regRdata <= {28'h0, pid_reg};
                OFS_ENDPOINT: regRdata <= {27'h0, endp_reg};
                OFS_EPMATCH:  regRdata <= {16'h0, epMatch_reg};
                default:      regRdata <= 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // checks
    chk_addr_filter: assert property (
        @(posedge clock) disable iff (!nrst)
        packetAccept |-> $past(token.valid) && $past(token.addr) ==
        $past(devAddr_reg)) else $error("accepted foreign packet");
    chk_func_out: assert property (
        @(posedge clock) disable iff (!nrst)
        !$past(modRst) |-> opMode == $past(funcCtl_reg[4:2]))
        else $error("opmode not from control");
    chk_txen_pol: assert property (
        @(posedge clock) disable iff (!nrst)
        $past(serial_reg[1]) == 1'b0 |-> !txEnable_n)
        else $error("tx enable polarity");
    chk_ls_gate: assert property (
        @(posedge clock) disable iff (!nrst)
        !lsEn && !modRst && !$past(modRst) && flags_reg[5:3] == 3'h0
        |=> flags_reg[5:3] == 3'h0)
        else $error("line flag while decoder off");
    chk_sticky_hold: assert property (
        @(posedge clock) disable iff (!nrst)
        sticky_reg[2] && flags_reg[2] && !flagClr[2] && !modRst
        |=> flags_reg[2]) else $error("sticky flag lost");
    chk_set_wins: assert property (
        @(posedge clock) disable iff (!nrst)
        dataCrcFail && !modRst |=> flags_reg[2])
        else $error("crc16 event lost");
    chk_rxact_track: assert property (
        @(posedge clock) disable iff (!nrst)
        !sticky_reg[1] && !modRst |=> flags_reg[1] == $past(rxActSync))
        else $error("rxactive flag not tracking");
    chk_mod_reset: assert property (
        @(posedge clock) disable iff (!nrst)
        modRst |=> devAddr_reg == 7'h00 && endp_reg == 5'h00 &&
        flags_reg == 7'h00) else $error("module reset incomplete");
    chk_port_or: assert property (
        @(posedge clock) disable iff (!nrst)
        |({1'b0, flags_reg} & portMask_reg[7:0]) |=> flagPortFirst)
        else $error("flag port first missed");
    chk_port_third: assert property (
        @(posedge clock) disable iff (!nrst)
        |({1'b0, flags_reg} & portMask_reg[23:16]) |=> flagPortThird)
        else $error("flag port third missed");
    chk_pid_capture: assert property (
        @(posedge clock) disable iff (!nrst)
        token.valid && !modRst |=> pid_reg == $past(token.pid))
        else $error("packet id not captured");
    chk_frame_sof: assert property (
        @(posedge clock) disable iff (!nrst)
        tokGood && token.pid == PID_SOF && !modRst &&
        !(regWrite && regAddr == OFS_FRAME)
        |=> frame_reg == $past(token.frame)) else $error("frame not loaded");
    chk_endp_store: assert property (
        @(posedge clock) disable iff (!nrst)
        tokMine && token.pid != PID_SOF && !modRst
        |=> endp_reg == {1'b1, $past(token.endp)})
        else $error("endpoint not stored");
    chk_ep_tag: assert property (
        @(posedge clock) disable iff (!nrst)
        tokMine && epMatch_reg[token.endp]
        |=> rxPortData[4] && rxPortData[3:0] == $past(token.endp))
        else $error("matched endpoint not tagged");
    chk_token_flag: assert property (
        @(posedge clock) disable iff (!nrst)
        tokMine && !modRst |=> flags_reg[BIT_TOKEN])
        else $error("token flag not set");
    chk_line_se0: assert property (
        @(posedge clock) disable iff (!nrst)
        lsEn && lsSync == LS_SE0 && !modRst |=> flags_reg[BIT_SE0])
        else $error("se0 flag not set");
    chk_pkt_clear: assert property (
        @(posedge clock) disable iff (!nrst)
        packetStart && !sticky_reg[BIT_TOKEN] && !tokMine && !modRst
        |=> !flags_reg[BIT_TOKEN])
        else $error("plain flag kept over packet");
    chk_sticky_clr: assert property (
        @(posedge clock) disable iff (!nrst)
        sticky_reg[BIT_CRC16] && flagClr[BIT_CRC16] && !dataCrcFail &&
        !modRst |=> !flags_reg[BIT_CRC16])
        else $error("sticky flag not cleared");
    chk_otg_out: assert property (
        @(posedge clock) disable iff (!nrst)
        otgCtl == $past({otgCtl_reg[7:6], otgCtl_reg[4:0]}))
        else $error("otg outputs not from control");
    chk_tx_out: assert property (
        @(posedge clock) disable iff (!nrst)
        {txSe0, txData, fsLsSerial} == $past({serial_reg[3:2], serial_reg[0]}))
        else $error("serial outputs not from control");
    chk_rxerr_track: assert property (
        @(posedge clock) disable iff (!nrst)
        !sticky_reg[BIT_RXERR] && !modRst
        |=> flags_reg[BIT_RXERR] == $past(rxErrSync))
        else $error("rxerror flag not tracking");

endmodule : uim_regs
`default_nettype wire

// file: dv/uim_utmi_model.sv
`timescale 1ns/1ns
`default_nettype none

module uim_utmi_model
    import uim_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic [12:0]          want,
    output logic      [1:0]           lineState,
    output logic                      rxActive,
    output logic                      rxError,
    output logic                      rxRcv,
    output logic                      rxDm,
    output logic                      rxDp,
    output uim_pkg::uim_otg_status_t  otgStatus
);
    // ==========================================================
    // transceiver levels
    // idle line is the undecoded code 3 so no flag fires unasked
    initial begin
        {otgStatus, rxDp, rxDm, rxRcv, rxError, rxActive, lineState} = 13'h3;
        forever begin
            @(posedge clock);
            {otgStatus, rxDp, rxDm, rxRcv, rxError, rxActive, lineState}
                <= want;
        end
    end
endmodule : uim_utmi_model

`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    import uim_pkg::*;

    logic             clock;
    logic             nrst;
    logic             regWrite;
    logic             regRead;
    logic [7:0]       regAddr;
    logic [31:0]      regWdata;
    logic [31:0]      regRdata;
    uim_token_t       token;
    logic             packetStart;
    logic             dataCrcFail;
    logic [12:0]      want;
    logic [1:0]       lineState;
    logic             rxActive;
    logic             rxError;
    logic             rxRcv;
    logic             rxDm;
    logic             rxDp;
    uim_otg_status_t  otgStatus;
    logic             packetAccept;
    logic [2:0]       opMode;
    logic             termSelect;
    logic             xcvrSelect;
    uim_otg_ctl_t     otgCtl;
    logic             txSe0;
    logic             txData;
    logic             txEnable_n;
    logic             fsLsSerial;
    logic             flagPortFirst;
    logic             flagPortSecond;
    logic             flagPortThird;
    logic [7:0]       rxPortData;
    logic             rxPortValid;
    int               n_fail;
    int               comparisons;
    localparam logic [6:0] DEV = 7'h12;
    localparam logic [7:0] RA [14] = '{OFS_DEVADDR, OFS_FUNCCTL, OFS_OTGCTL,
        OFS_OTGFLAGS, OFS_SERIAL, OFS_EVFLAGS, OFS_STICKY, OFS_PORTMASK,
        OFS_FRAME, OFS_PID, OFS_ENDPOINT, OFS_EPMATCH, OFS_GENCTL, 8'h3c};
    localparam logic [31:0] RV [14] = '{32'h0, 32'h7, 32'h0, 32'h0, 32'h2,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] WV [9] = '{32'h7f, 32'h1f, 32'hdf, 32'h0,
        32'h0f, 32'h0, 32'h7f, 32'hffffff, 32'h7ff};

    uim_utmi_model i_utmi (.clock, .want, .lineState, .rxActive, .rxError,
        .rxRcv, .rxDm, .rxDp, .otgStatus);

    uim_regs i_dut (.clock, .nrst, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .token, .packetStart, .dataCrcFail, .lineState, .rxActive,
        .rxError, .rxRcv, .rxDm, .rxDp, .otgStatus, .packetAccept, .opMode,
        .termSelect, .xcvrSelect, .otgCtl, .txSe0, .txData, .txEnable_n,
        .fsLsSerial, .flagPortFirst, .flagPortSecond, .flagPortThird,
        .rxPortData, .rxPortValid);

    // ==========================================================
    // clock and watchdog
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        #2_000_000;
        n_fail++;
        final_report();
    end

    // ==========================================================
    // access tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle

    // outputs follow one edge after the register, so wait two edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        @(negedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        @(negedge clock);
        chk(regRdata, exp);
    endtask : rd

    task automatic tok(input logic [3:0] p, input logic [6:0] a,
                       input logic [3:0] e, input logic ok);
        token = '{valid: 1'b1, pid: p, addr: a, endp: e, frame: 11'h5a5,
                  crc5Ok: ok, pidOk: 1'b1};
        @(negedge clock);
        token.valid = 1'b0;
    endtask : tok

    task automatic pstart();
        packetStart = 1'b1;
        @(negedge clock);
        packetStart = 1'b0;
    endtask : pstart

    task automatic reset_table();
        for (int i = 0; i < 14; i++)
            rd(RA[i], RV[i]);
        chk(32'({opMode, termSelect, xcvrSelect, otgCtl}), 32'h380);
        chk(32'({txSe0, txData, txEnable_n, fsLsSerial}), 32'h2);
    endtask : reset_table

    task automatic final_report();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // ==========================================================
    // scenarios
    initial begin
        n_fail = 0;
        comparisons = 0;
        nrst = 1'b0;
        {regWrite, regRead, packetStart, dataCrcFail} = 4'h0;
        regAddr = 8'h0;
        regWdata = 32'h0;
        token = '0;
        want = 13'h3;
        idle(4);
        nrst = 1'b1;
        reset_table();
        for (int i = 0; i < 9; i++) begin
            wr(RA[i], 32'hffffffff);
            rd(RA[i], WV[i]);
        end
        chk(32'({opMode, termSelect, xcvrSelect, otgCtl}), 32'hfff);
        chk(32'({txSe0, txData, txEnable_n, fsLsSerial}), 32'hf);
        wr(OFS_FRAME, 32'h0000_0123);
        rd(OFS_FRAME, 32'h123);
        wr(OFS_SERIAL, 32'h0);
        chk(32'({txSe0, txData, txEnable_n, fsLsSerial}), 32'h0);
        wr(OFS_RESET, 32'h5a);
        reset_table();
        want = 13'h1553;
        idle(4);
        rd(OFS_OTGFLAGS, 32'h2a);
        rd(OFS_SERIAL, 32'h52);
        want = 13'h3;
        wr(OFS_DEVADDR, 32'(DEV));
        wr(OFS_PORTMASK, 32'h0002_0440);
        tok(4'h9, DEV, 4'h3, 1'b1);
        chk(32'({packetAccept, rxPortValid, rxPortData}), 32'h303);
        idle(1);
        chk(32'({flagPortFirst, packetAccept}), 32'h2);
        rd(OFS_EVFLAGS, 32'h40);
        pstart();
        rd(OFS_EVFLAGS, 32'h0);
        wr(OFS_STICKY, 32'h44);
        tok(4'h1, DEV, 4'h3, 1'b1);
        dataCrcFail = 1'b1;
        @(negedge clock);
        dataCrcFail = 1'b0;
        pstart();
        rd(OFS_EVFLAGS, 32'h44);
        chk(32'({flagPortFirst, flagPortSecond, flagPortThird}), 32'h6);
        wr(OFS_EVFLAGS, 32'h40);
        rd(OFS_EVFLAGS, 32'h04);
        wr(OFS_EVFLAGS, 32'h04);
        want = 13'h7;
        idle(4);
        rd(OFS_EVFLAGS, 32'h02);
        chk(32'(flagPortThird), 32'h1);
        want = 13'hb;
        idle(4);
        rd(OFS_EVFLAGS, 32'h01);
        want = 13'h0;
        idle(4);
        want = 13'h3;
        idle(4);
        pstart();
        rd(OFS_EVFLAGS, 32'h0);
        wr(OFS_GENCTL, 32'h4);
        for (int i = 0; i < 3; i++) begin
            pstart();
            want = {11'h0, (i == 0) ? LS_SE0 : (i == 1) ? LS_K : LS_J};
            idle(4);
            want = 13'h3;
            idle(4);
            rd(OFS_EVFLAGS, 32'h20 >> i);
        end
        wr(OFS_EPMATCH, 32'h0008);
        tok(4'h9, DEV, 4'h3, 1'b1);
        chk(32'({packetAccept, rxPortValid, rxPortData}), 32'h313);
        rd(OFS_ENDPOINT, 32'h13);
        tok(4'h1, DEV ^ 7'h1, 4'h7, 1'b1);
        chk(32'({packetAccept, rxPortValid}), 32'h0);
        idle(1);
        tok(4'h1, DEV, 4'h7, 1'b0);
        chk(32'({packetAccept, rxPortValid}), 32'h0);
        rd(OFS_ENDPOINT, 32'h13);
        rd(OFS_PID, 32'h1);
        tok(PID_SOF, DEV, 4'h0, 1'b1);
        rd(OFS_FRAME, 32'h5a5);
        rd(OFS_PID, 32'(PID_SOF));
        wr(OFS_RESET, 32'h0);
        rd(OFS_ENDPOINT, 32'h0);
        final_report();
    end
endmodule : tb

`default_nettype wire
